// ---- ssp_top.sv ----
// Purpose: Access policy of slots 14 and 15, the one-time zone and volatile buffers
// Assumes: APB slave, zero wait states, one clock
// Notes: Commands run for one busy cycle after a CMD write
//
// Summary of operation
// - Slot 14 writes need prior invalidation
// - Slot 14 verify only while validated
// - Slot 14 always reads in clear
// - Slot 14 uses invalidate_before_write_mode operation set
// - Lockable slot 15 writable until locked
// - Permanently locked slot 15 rejects writes
// - One-time zone: 64 bytes, two blocks
// - One-time zone rejects every modification
// - One-time zone reads of 4 or 32 bytes
// - Volatile memory never read out directly
// - Sleep or power loss invalidates volatile memory
// - 64-byte intermediate_value_store, halves, hidden
// - Alternate key from nonce or derivation
// - Hash context survives between phases
//
// Local design decisions: the APB slave port and the address map.
`include "ssp_map.svh"
`timescale 1ns/100ps
`default_nettype none
module ssp_top (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_sleep,
   input wire logic i_boot_perm,
   output var ssp_pkg::ssp_status_type o_status,
   output logic o_busy
);
   import ssp_pkg::*;
   // ----------------------------------------
   // Storage
   // ----------------------------------------
   logic [31:0] vpk_m [`SSP_ZONE_WORDS];
   logic [31:0] boot_m [`SSP_ZONE_WORDS];
   logic [31:0] ivs_m [`SSP_ZONE_WORDS];
   logic [31:0] dig_m [`SSP_ZONE_WORDS];
   logic [31:0] alt_m [`SSP_BLK_WORDS];
   logic [31:0] ctx_m [`SSP_BLK_WORDS];
   logic [31:0] rbuf_q [`SSP_BLK_WORDS];
   logic [31:0] rbuf_d [`SSP_BLK_WORDS];
   ssp_state_type state_q, state_d;
   logic [31:0] cmd_q, cmd_d, wdata_q, wdata_d, prdata_q, prdata_d;
   logic [2:0] rptr_q, rptr_d;
   logic rlen_q, rlen_d;
   ssp_status_type status_q, status_d;
   logic vpk_ok_q, vpk_ok_d, lock_q, lock_d, perm_q, perm_d, strap_q;
   logic ivs_v_q, ivs_v_d, dig_v_q, dig_v_d, alt_v_q, alt_v_d, ctx_v_q, ctx_v_d;
   logic we_vpk, we_boot, we_ivs, we_alt, we_ctx, ctx_clr, ctx_to_dig, ctx_to_ivs;
   logic [31:0] wr_word;
   logic setup, access, hit, cmd_wr, rd_pop;
   ssp_cmd_type op;
   logic [3:0] slot, idx;
   logic otp, is_vpk, is_boot;

   // Stand-in mixing step for hash update, authentication and derivation
   function automatic logic [31:0] mix(input logic [31:0] a, input logic [31:0] b);
      mix = {a[26:0], a[31:27]} ^ (b + 32'h9e37_79b9);
   endfunction

   // One-time zone contents, 16 words in two 8-word blocks
   function automatic logic [31:0] otp_word(input logic [3:0] i);
      otp_word = `SSP_RST_WORD;
      if (i == 4'h0) begin
         otp_word = 32'(`SSP_OTP_TAG >> 32);
      end else if (i == 4'h1) begin
         otp_word = 32'(`SSP_OTP_TAG);
      end
   endfunction

   // Readable word of the addressed zone; volatile arrays have no path here
   function automatic logic [31:0] zone_word(input logic [3:0] i);
      if (otp) begin
         zone_word = otp_word(i);
      end else if (is_vpk) begin
         zone_word = vpk_m[i];
      end else begin
         zone_word = boot_m[i];
      end
   endfunction

   // ----------------------------------------
   // Command decode and bus strobes
   // ----------------------------------------
   assign op = ssp_cmd_type'(cmd_q[`SSP_OP_LSB +: 4]);
   assign slot = cmd_q[`SSP_SLOT_LSB +: 4];
   assign idx = cmd_q[`SSP_IDX_LSB +: 4];
   assign otp = cmd_q[`SSP_OTP_BIT];
   assign is_vpk = !otp && slot == `SSP_SLOT_VPK;
   assign is_boot = !otp && slot == `SSP_SLOT_BOOT;
   assign setup = i_psel && !i_penable;
   assign access = i_psel && i_penable;
   assign hit = i_paddr == `SSP_ADDR_CMD || i_paddr == `SSP_ADDR_WDATA ||
                i_paddr == `SSP_ADDR_RDATA || i_paddr == `SSP_ADDR_STATUS;
   assign cmd_wr = access && i_pwrite && i_paddr == `SSP_ADDR_CMD && state_q == ssp_st_idle;
   assign rd_pop = access && !i_pwrite && i_paddr == `SSP_ADDR_RDATA;
   assign o_pready = access;
   // Unmapped, read-only write, or command while busy
   assign o_pslverr = access && (!hit || (i_pwrite && (i_paddr == `SSP_ADDR_RDATA ||
                      i_paddr == `SSP_ADDR_STATUS)) ||
                      (i_pwrite && i_paddr == `SSP_ADDR_CMD && state_q != ssp_st_idle));
   assign o_prdata = prdata_q;
   assign o_status = status_q;
   assign o_busy = state_q == ssp_st_busy;

   // ----------------------------------------
   // Next state of control, flags and read buffer
   // ----------------------------------------
   always_comb begin
      state_d = state_q;
      cmd_d = cmd_q;
      wdata_d = wdata_q;
      rbuf_d = rbuf_q;
      rptr_d = rptr_q;
      rlen_d = rlen_q;
      status_d = status_q;
      vpk_ok_d = vpk_ok_q;
      lock_d = lock_q;
      perm_d = strap_q ? perm_q : i_boot_perm;
      ivs_v_d = ivs_v_q;
      dig_v_d = dig_v_q;
      alt_v_d = alt_v_q;
      ctx_v_d = ctx_v_q;
      we_vpk = 1'b0;
      we_boot = 1'b0;
      we_ivs = 1'b0;
      we_alt = 1'b0;
      we_ctx = 1'b0;
      ctx_clr = 1'b0;
      ctx_to_dig = 1'b0;
      ctx_to_ivs = 1'b0;
      wr_word = wdata_q;
      prdata_d = prdata_q;
      // Read data is staged in the setup cycle
      if (setup && !i_pwrite) begin
         prdata_d = `SSP_RST_WORD;
         case (i_paddr)
            `SSP_ADDR_CMD: prdata_d = cmd_q;
            `SSP_ADDR_WDATA: prdata_d = wdata_q;
            `SSP_ADDR_RDATA: prdata_d = rbuf_q[rptr_q];
            `SSP_ADDR_STATUS: prdata_d = {16'h0000, o_busy, perm_q, lock_q, vpk_ok_q,
                                          ivs_v_q, dig_v_q, alt_v_q, ctx_v_q, status_q};
            default: prdata_d = `SSP_RST_WORD;
         endcase
      end
      if (access && i_pwrite && i_paddr == `SSP_ADDR_WDATA) begin
         wdata_d = i_pwdata;
      end
      if (rd_pop && rlen_q) begin
         rptr_d = rptr_q + 3'h1;
      end
      if (cmd_wr) begin
         cmd_d = i_pwdata;
         state_d = ssp_st_busy;
      end
      if (state_q == ssp_st_busy) begin
         state_d = ssp_st_idle;
         status_d = `SSP_ST_REFUSED; // Default refusal leaves storage untouched
         unique case (op)
            ssp_op_read: begin
               if (otp || is_vpk || is_boot) begin // Clear reads, any validation state
                  rlen_d = cmd_q[`SSP_LEN32_BIT];
                  rptr_d = 3'h0;
                  for (int i = 0; i < `SSP_BLK_WORDS; i++) begin
                     rbuf_d[i] = cmd_q[`SSP_LEN32_BIT] ? zone_word({idx[3], 3'(i)}) :
                                 (i == 0 ? zone_word(idx) : `SSP_RST_WORD);
                  end
                  status_d = `SSP_ST_OK;
               end
            end
            ssp_op_write: begin
               if (is_vpk && !vpk_ok_q) begin // Only after invalidation
                  we_vpk = 1'b1;
                  status_d = `SSP_ST_OK;
               end else if (is_boot && !perm_q && !lock_q) begin
                  we_boot = 1'b1;
                  status_d = `SSP_ST_OK;
               end
               // The one-time zone is shipped locked and never written
            end
            ssp_op_lock: begin
               if (is_boot) begin // Per_slot_lock allowed in both options
                  lock_d = 1'b1;
                  status_d = `SSP_ST_OK;
               end
            end
            ssp_op_vfy_val: begin
               if (is_vpk) begin // Validate against the digest buffer
                  vpk_ok_d = dig_v_q;
                  status_d = dig_v_q ? `SSP_ST_OK : `SSP_ST_MISCMP;
               end
            end
            ssp_op_vfy_inval: begin
               if (is_vpk) begin
                  vpk_ok_d = 1'b0;
                  status_d = `SSP_ST_OK;
               end
            end
            ssp_op_vfy_stored: begin
               if (is_vpk && vpk_ok_q) begin // Stored key only while validated
                  status_d = dig_v_q ? `SSP_ST_OK : `SSP_ST_MISCMP;
               end
            end
            ssp_op_mac: begin
               if (is_boot && ivs_v_q) begin // Slot as data source, result only
                  rlen_d = 1'b0;
                  rptr_d = 3'h0;
                  rbuf_d[0] = mix(boot_m[idx], ivs_m[idx]);
                  status_d = `SSP_ST_OK;
               end
            end
            ssp_op_digest_generate_cmd: begin
               if (is_boot) begin // Slot data into the store
                  we_ivs = 1'b1;
                  wr_word = mix(boot_m[idx], ivs_m[idx]);
                  ivs_v_d = 1'b1;
                  status_d = `SSP_ST_OK;
               end
            end
            ssp_op_nonce: begin // Fixed input value
               we_alt = 1'b1;
               alt_v_d = 1'b1;
               status_d = `SSP_ST_OK;
            end
            ssp_op_kdf: begin
               if (ivs_v_q) begin // Secret derived from the store
                  we_alt = 1'b1;
                  wr_word = mix(ivs_m[idx], wdata_q);
                  alt_v_d = 1'b1;
                  status_d = `SSP_ST_OK;
               end
            end
            ssp_op_hash_init: begin
               ctx_clr = 1'b1;
               ctx_v_d = 1'b1;
               status_d = `SSP_ST_OK;
            end
            ssp_op_hash_update: begin
               if (ctx_v_q) begin // Repeatable update
                  we_ctx = 1'b1;
                  wr_word = mix(ctx_m[idx[2:0]], wdata_q);
                  status_d = `SSP_ST_OK;
               end
            end
            ssp_op_hash_final: begin
               if (ctx_v_q) begin // Digest to buffer or store
                  ctx_to_dig = cmd_q[`SSP_TODIG_BIT];
                  ctx_to_ivs = !cmd_q[`SSP_TODIG_BIT];
                  dig_v_d = cmd_q[`SSP_TODIG_BIT] || dig_v_q;
                  ivs_v_d = !cmd_q[`SSP_TODIG_BIT] || ivs_v_q;
                  ctx_v_d = 1'b0;
                  status_d = `SSP_ST_OK;
               end
            end
            default: status_d = `SSP_ST_PARSE;
         endcase
      end
      // Sleep wins over any set in the same cycle
      if (i_sleep) begin
         ivs_v_d = 1'b0;
         dig_v_d = 1'b0;
         alt_v_d = 1'b0;
         ctx_v_d = 1'b0;
      end
   end

   // Control registers; power loss acts through reset
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_q <= ssp_st_idle;
         cmd_q <= `SSP_RST_WORD;
         wdata_q <= `SSP_RST_WORD;
         prdata_q <= `SSP_RST_WORD;
         rbuf_q <= '{default: `SSP_RST_WORD};
         rptr_q <= 3'h0;
         rlen_q <= 1'b0;
         status_q <= `SSP_RST_STATUS;
         vpk_ok_q <= 1'b0;
         lock_q <= 1'b0;
         perm_q <= 1'b0;
         strap_q <= 1'b0;
         ivs_v_q <= 1'b0;
         dig_v_q <= 1'b0;
         alt_v_q <= 1'b0;
         ctx_v_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cmd_q <= cmd_d;
         wdata_q <= wdata_d;
         prdata_q <= prdata_d;
         rbuf_q <= rbuf_d;
         rptr_q <= rptr_d;
         rlen_q <= rlen_d;
         status_q <= status_d;
         vpk_ok_q <= vpk_ok_d;
         lock_q <= lock_d;
         perm_q <= perm_d;
         strap_q <= 1'b1;
         ivs_v_q <= ivs_v_d;
         dig_v_q <= dig_v_d;
         alt_v_q <= alt_v_d;
         ctx_v_q <= ctx_v_d;
      end
   end

   // ----------------------------------------
   // Storage arrays, written only by granted commands
   // ----------------------------------------
   always_ff @(posedge i_clk) begin
      if (we_vpk) begin
         vpk_m[idx] <= wr_word;
      end
      if (we_boot) begin
         boot_m[idx] <= wr_word;
      end
      if (we_ivs) begin
         ivs_m[idx] <= wr_word;
      end
      if (we_alt) begin
         alt_m[idx[2:0]] <= wr_word;
      end
      for (int i = 0; i < `SSP_BLK_WORDS; i++) begin
         if (ctx_clr) begin
            ctx_m[i] <= `SSP_RST_WORD;
         end else if (we_ctx && idx[2:0] == 3'(i)) begin
            ctx_m[i] <= wr_word;
         end
         if (ctx_to_dig) begin
            dig_m[i] <= ctx_m[i];
         end
         if (ctx_to_ivs) begin
            ivs_m[i] <= ctx_m[i];
         end
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_vpk_write_block: assert property (@(posedge i_clk) disable iff (i_rst)
      o_busy && op == ssp_op_write && is_vpk && vpk_ok_q |=> status_q == `SSP_ST_REFUSED)
      else $error("validated key slot written");
   a_vpk_verify_gate: assert property (@(posedge i_clk) disable iff (i_rst)
      o_busy && op == ssp_op_vfy_stored && !vpk_ok_q |=> status_q == `SSP_ST_REFUSED)
      else $error("stored verify used unvalidated key");
   a_vpk_read_ok: assert property (@(posedge i_clk) disable iff (i_rst)
      o_busy && op == ssp_op_read && is_vpk |=> status_q == `SSP_ST_OK && rptr_q == 3'h0)
      else $error("clear read of key slot refused");
   a_boot_perm_write: assert property (@(posedge i_clk) disable iff (i_rst)
      o_busy && op == ssp_op_write && is_boot && perm_q |-> !we_boot ##1 status_q != `SSP_ST_OK)
      else $error("locked boot slot written");
   a_boot_lock_hold: assert property (@(posedge i_clk) disable iff (i_rst)
      lock_q |=> lock_q)
      else $error("slot lock released");
   a_otp_write: assert property (@(posedge i_clk) disable iff (i_rst)
      o_busy && op == ssp_op_write && otp |=> status_q == `SSP_ST_REFUSED)
      else $error("one-time zone write accepted");
   a_sleep_clear: assert property (@(posedge i_clk) disable iff (i_rst)
      i_sleep |=> !ivs_v_q && !dig_v_q && !alt_v_q && !ctx_v_q)
      else $error("volatile data valid after sleep");
   a_refuse_keeps: assert property (@(posedge i_clk) disable iff (i_rst)
      status_d == `SSP_ST_REFUSED && o_busy |-> !we_vpk && !we_boot && !we_ivs)
      else $error("refused command changed storage");
   a_ctx_keep: assert property (@(posedge i_clk) disable iff (i_rst)
      ctx_v_q && !i_sleep && !(o_busy && op == ssp_op_hash_final) |=> ctx_v_q)
      else $error("hash context lost between phases");
   a_cmd_busy: assert property (@(posedge i_clk) disable iff (i_rst)
      cmd_wr |=> o_busy ##1 !o_busy)
      else $error("command not run in one cycle");
endmodule
`default_nettype wire

// ---- ssp_map.svh ----
// Purpose: Offsets, field positions, codes and reset values
// Assumes: Included once per compile unit
// Notes: Byte addresses on a 32-bit APB bus
`ifndef SSP_MAP_SVH
`define SSP_MAP_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SSP_ADDR_CMD 12'h000
`define SSP_ADDR_WDATA 12'h004
`define SSP_ADDR_RDATA 12'h008
`define SSP_ADDR_STATUS 12'h00c
// ----------------------------------------
// Command word fields
// ----------------------------------------
`define SSP_OP_LSB 0
`define SSP_SLOT_LSB 4
`define SSP_OTP_BIT 8
`define SSP_LEN32_BIT 9
`define SSP_TODIG_BIT 10
`define SSP_IDX_LSB 12
// ----------------------------------------
// Slot numbers and sizes
// ----------------------------------------
`define SSP_SLOT_VPK 4'he
`define SSP_SLOT_BOOT 4'hf
`define SSP_ZONE_WORDS 16
`define SSP_BLK_WORDS 8
// Arbitrary tag held in the first eight one-time bytes
`define SSP_OTP_TAG 64'h0123_4567_89ab_cdef
// ----------------------------------------
// Status codes and reset values
// ----------------------------------------
`define SSP_ST_OK 8'h00
`define SSP_ST_MISCMP 8'h01
`define SSP_ST_PARSE 8'h03
`define SSP_ST_REFUSED 8'h0f
`define SSP_RST_STATUS 8'h00
`define SSP_RST_WORD 32'h0000_0000
`endif

// ---- ssp_pkg.sv ----
// Purpose: Types shared by the slot policy block
// Assumes: Nothing
// Notes: Codes are in ssp_map.svh
package ssp_pkg;
   typedef logic [7:0] ssp_status_type;
   typedef enum logic [3:0] {
      ssp_op_read = 4'h0,
      ssp_op_write = 4'h1,
      ssp_op_lock = 4'h2,
      ssp_op_vfy_val = 4'h3,
      ssp_op_vfy_inval = 4'h4,
      ssp_op_vfy_stored = 4'h5,
      ssp_op_mac = 4'h6,
      ssp_op_digest_generate_cmd = 4'h7,
      ssp_op_nonce = 4'h8,
      ssp_op_kdf = 4'h9,
      ssp_op_hash_init = 4'ha,
      ssp_op_hash_update = 4'hb,
      ssp_op_hash_final = 4'hc
   } ssp_cmd_type;
   typedef enum logic [1:0] {
      ssp_st_idle = 2'b01,
      ssp_st_busy = 2'b10
   } ssp_state_type;
endpackage

// ---- ssp_host.sv ----
// Purpose: Host side model that issues register transfers to the slot policy block
// Assumes: One clock, slave may insert wait states
// Notes: Released write data is inverted so stale values never look valid
`timescale 1ns/100ps
`default_nettype none
module ssp_host (
   input wire logic i_clk,
   input wire logic [31:0] i_prdata,
   input wire logic i_pready,
   input wire logic i_pslverr,
   output logic o_psel,
   output logic o_penable,
   output logic o_pwrite,
   output logic [11:0] o_paddr,
   output logic [31:0] o_pwdata
);
   logic timed_out;
   // Idle bus at time zero
   initial begin
      o_psel = 1'b0;
      o_penable = 1'b0;
      o_pwrite = 1'b0;
      o_paddr = 12'h000;
      o_pwdata = 32'h0000_0000;
      timed_out = 1'b0;
   end
   // Host never asks for an updatable parent key slot; only slots 14, 15, the zone and, in the error test, slot 3
   // One transfer: setup, access held until ready, then release
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
         output logic err);
      int n;
      n = 0;
      @(posedge i_clk);
      o_psel <= 1'b1;
      o_penable <= 1'b0;
      o_pwrite <= w;
      o_paddr <= a;
      o_pwdata <= d;
      @(posedge i_clk);
      o_penable <= 1'b1;
      do begin
         @(posedge i_clk);
         n++;
      end while (i_pready !== 1'b1 && n < 64);
      timed_out = (n >= 64);
      rd = i_prdata;
      err = i_pslverr;
      o_psel <= 1'b0;
      o_penable <= 1'b0;
      o_pwdata <= ~d;
   endtask
endmodule
`default_nettype wire

// ---- secure_slot_policy_and_buffers_bench.sv ----
// Purpose: Self-checking bench for the slot policy block
// Assumes: Host model drives the register bus
// Notes: Status is compared two edges after each command is taken
`include "ssp_map.svh"
`timescale 1ns/100ps
`default_nettype none
module secure_slot_policy_and_buffers_bench;
   import ssp_pkg::*;
   localparam logic [7:0] ok = `SSP_ST_OK;
   localparam logic [7:0] rf = `SSP_ST_REFUSED;
   localparam logic [3:0] s14 = `SSP_SLOT_VPK;
   localparam logic [3:0] s15 = `SSP_SLOT_BOOT;
   logic clk, rst, psel, pen, pwr, slp, perm, pready, pslverr, busy, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, d1, d2;
   logic [3:0] ix;
   ssp_status_type status;
   int n_fail, num_checks;
   // ----------------------------------------
   // Clock, design and host
   // ----------------------------------------
   always #2 clk = ~clk;
   ssp_top dut_u (.i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_sleep(slp),
      .i_boot_perm(perm), .o_status(status), .o_busy(busy));
   ssp_host host_u (.i_clk(clk), .i_prdata(prdata), .i_pready(pready), .i_pslverr(pslverr), .o_psel(psel),
      .o_penable(pen), .o_pwrite(pwr), .o_paddr(paddr), .o_pwdata(pwdata));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   // One register transfer, result left in rd and er
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      host_u.xfer(w, a, d, rd, er);
      if (host_u.timed_out) begin
         n_fail++;
         $display("unexpected at %0t: no ready", $time);
      end
   endtask
   // Command word layout
   function automatic logic [31:0] cmd_word(input logic [3:0] op, sl, ix, input logic [2:0] md);
      return {16'h0000, ix, 1'b0, md, sl, op};
   endfunction
   // Expected code of a write to the boot key slot
   function automatic ssp_status_type wr15(input logic lk, pm);
      return (lk | pm) ? rf : ok;
   endfunction
   // Issue a command, watch the busy cycle, then the status code
   task automatic cmd(input logic [3:0] op, sl, ix, input logic [2:0] md, input ssp_status_type ex);
      bus(1'b1, `SSP_ADDR_CMD, cmd_word(op, sl, ix, md));
      #1;
      check(busy, 1'b1, "busy pulse");
      repeat (2) @(posedge clk);
      #1;
      check(status, ex, "status code");
   endtask
   task automatic rdw;
      bus(1'b0, `SSP_ADDR_RDATA, 32'h0000_0000);
   endtask
   task automatic stat;
      bus(1'b0, `SSP_ADDR_STATUS, 32'h0000_0000);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #80000;
      n_fail++;
      $display("unexpected at %0t: watchdog", $time);
      end_of_test();
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      slp = 1'b0;
      perm = 1'b0;
      n_fail = 0;
      num_checks = 0;
      void'($urandom(32'h11c2));
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      #1;
      check(status, `SSP_RST_STATUS, "reset status");
      // Validated key slot: write, validate, refuse, invalidate, rewrite
      d1 = $urandom;
      d2 = $urandom;
      ix = 4'($urandom_range(7, 0));
      bus(1'b1, `SSP_ADDR_WDATA, d1);
      cmd(ssp_op_write, s14, ix, 3'b000, ok);
      cmd(ssp_op_hash_init, 4'h0, 4'h0, 3'b000, ok);
      bus(1'b1, `SSP_ADDR_WDATA, d2);
      cmd(ssp_op_hash_update, 4'h0, 4'h0, 3'b000, ok);
      cmd(ssp_op_hash_update, 4'h0, 4'h0, 3'b000, ok);
      cmd(ssp_op_hash_final, 4'h0, 4'h0, 3'b100, ok);
      cmd(ssp_op_vfy_val, s14, 4'h0, 3'b000, ok);
      stat();
      check(rd & 32'h1000, 32'h1000, "validated flag");
      cmd(ssp_op_vfy_stored, s14, 4'h0, 3'b000, ok);
      cmd(ssp_op_write, s14, ix, 3'b000, rf);
      cmd(ssp_op_lock, s14, 4'h0, 3'b000, rf);
      cmd(ssp_op_read, s14, ix, 3'b000, ok);
      rdw();
      check(rd, d1, "slot 14 word kept");
      cmd(ssp_op_vfy_inval, s14, 4'h0, 3'b000, ok);
      cmd(ssp_op_vfy_stored, s14, 4'h0, 3'b000, rf);
      cmd(ssp_op_write, s14, ix, 3'b000, ok);
      cmd(ssp_op_read, s14, ix, 3'b000, ok);
      rdw();
      check(rd, d2, "slot 14 word new");
      $display("test validated key slot done");
      // Volatile buffers and sleep
      cmd(ssp_op_nonce, 4'h0, 4'h0, 3'b000, ok);
      cmd(ssp_op_hash_init, 4'h0, 4'h0, 3'b000, ok);
      stat();
      check(rd & 32'h0700, 32'h0700, "buffers valid");
      @(posedge clk);
      slp <= 1'b1;
      @(posedge clk);
      slp <= 1'b0;
      stat();
      check(rd & 32'h0f00, 32'h0000, "buffers cleared");
      cmd(ssp_op_hash_update, 4'h0, 4'h0, 3'b000, rf);
      cmd(ssp_op_kdf, 4'h0, 4'h0, 3'b000, rf);
      cmd(ssp_op_vfy_val, s14, 4'h0, 3'b000, `SSP_ST_MISCMP);
      cmd(ssp_op_hash_init, 4'h0, 4'h0, 3'b000, ok);
      cmd(ssp_op_hash_final, 4'h0, 4'h0, 3'b000, ok);
      stat();
      check(rd & 32'h0c00, 32'h0800, "store filled");
      cmd(ssp_op_kdf, 4'h0, 4'h0, 3'b000, ok);
      $display("test volatile buffers done");
      // Lockable boot key slot
      bus(1'b1, `SSP_ADDR_WDATA, d1);
      cmd(ssp_op_write, s15, ix, 3'b000, wr15(1'b0, 1'b0));
      cmd(ssp_op_mac, s15, 4'h0, 3'b000, ok);
      cmd(ssp_op_digest_generate_cmd, s15, 4'h0, 3'b000, ok);
      cmd(ssp_op_lock, s15, 4'h0, 3'b000, ok);
      stat();
      check(rd & 32'h6000, 32'h2000, "locked flag");
      bus(1'b1, `SSP_ADDR_WDATA, ~d1);
      cmd(ssp_op_write, s15, ix, 3'b000, wr15(1'b1, 1'b0));
      cmd(ssp_op_read, s15, ix, 3'b000, ok);
      rdw();
      check(rd, d1, "slot 15 word kept");
      $display("test lockable boot slot done");
      // Permanently locked option after a second reset
      @(posedge clk);
      rst <= 1'b1;
      perm <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      stat();
      check(rd & 32'h7000, 32'h4000, "flags after reset");
      bus(1'b1, `SSP_ADDR_WDATA, d2);
      cmd(ssp_op_write, s15, ix, 3'b000, wr15(1'b0, 1'b1));
      cmd(ssp_op_read, s15, ix, 3'b000, ok);
      rdw();
      check(rd, d1, "slot 15 word after reset");
      cmd(ssp_op_lock, s15, 4'h0, 3'b000, ok);
      // Reset invalidated the store, so digest generation marks it valid again before authentication
      cmd(ssp_op_digest_generate_cmd, s15, 4'h0, 3'b000, ok);
      cmd(ssp_op_mac, s15, 4'h0, 3'b000, ok);
      $display("test locked boot slot done");
      // One-time zone: write refused, both read lengths
      bus(1'b1, `SSP_ADDR_WDATA, d2 | 32'h1);
      cmd(ssp_op_write, 4'h0, 4'h3, 3'b001, rf);
      cmd(ssp_op_read, 4'h0, 4'h3, 3'b001, ok);
      rdw();
      check(rd, 32'h0000_0000, "one-time word");
      cmd(ssp_op_read, 4'h0, 4'h8, 3'b011, ok);
      for (int k = 0; k < 16; k++) begin
         if (k == 8) begin
            cmd(ssp_op_read, 4'h0, 4'h0, 3'b011, ok);
         end
         rdw();
         if (k < 8 || k > 9) begin
            check(rd, 32'h0000_0000, "one-time block");
         end else begin
            check(rd, (k == 8) ? 32'(`SSP_OTP_TAG >> 32) : 32'(`SSP_OTP_TAG), "one-time tag");
         end
      end
      $display("test one-time zone done");
      // Errors: bad opcode, unmodelled slot, bad addresses
      cmd(4'hd, 4'h0, 4'h0, 3'b000, `SSP_ST_PARSE);
      cmd(ssp_op_read, 4'h3, 4'h0, 3'b000, rf);
      bus(1'b0, 12'h010, 32'h0000_0000);
      check(er, 1'b1, "unmapped error");
      bus(1'b1, `SSP_ADDR_RDATA, d1);
      check(er, 1'b1, "read-only error");
      stat();
      check(er, 1'b0, "status read error");
      $display("test errors done");
      end_of_test();
   end
endmodule
`default_nettype wire
